/* File: rtl/amt_defines.svh */
// Constants for the access module message timing block.
`ifndef AMT_DEFINES_SVH
`define AMT_DEFINES_SVH
// Clock period in ns.
`define AMT_CLK_NS 10
// Processing budget after the ACK, in ns, and derived cycles (round down).
`define AMT_ACF_BUDGET_NS 47000
`define AMT_ACF_BUDGET_CYC (`AMT_ACF_BUDGET_NS / `AMT_CLK_NS)
// Latest load point into the epoch, in ns (65,74 us), and cycles.
`define AMT_LOAD_LATEST_NS 65740
`define AMT_LOAD_LATEST_CYC (`AMT_LOAD_LATEST_NS / `AMT_CLK_NS)
// In token deadline, in ns (73,5 us), and cycles.
`define AMT_IN_TOKEN_NS 73500
`define AMT_IN_TOKEN_CYC (`AMT_IN_TOKEN_NS / `AMT_CLK_NS)
// Epoch length, in ns (87,8 us), and cycles.
`define AMT_EPOCH_NS 87800
`define AMT_EPOCH_CYC (`AMT_EPOCH_NS / `AMT_CLK_NS)
// Fixed latency of the field computation in cycles.
`define AMT_CALC_CYC 16
// Message type identifiers, first byte of each outbound packet and of each inbound reply.
`define AMT_ID_HEALTH_IND 8'h01
`define AMT_ID_HEALTH_RSP 8'h81
`define AMT_ID_FCOUNT_IND 8'h02
`define AMT_ID_ACF_IND 8'h03
`define AMT_ID_ACF_RSP 8'h83
`define AMT_ID_ACF_FAIL 8'hc3
`define AMT_ID_BR_IND 8'h04
`define AMT_ID_BR_RSP 8'h84
`define AMT_ID_BR_FAIL 8'hc4
`define AMT_ID_BA_IND 8'h05
`define AMT_ID_BA_RSP 8'h85
`define AMT_ID_BA_REJ 8'hc5
`define AMT_ID_GEN_FAIL 8'hff
// Error codes.
`define AMT_ERR_NONE 8'h00
`define AMT_ERR_UNKNOWN 8'h01
`define AMT_ERR_NO_FCOUNT 8'h02
`define AMT_ERR_POLICY 8'h03
`define AMT_ERR_TOO_MANY 8'h04
`define AMT_ERR_TOO_LONG 8'h05
`define AMT_ERR_LATE 8'h06
// Packet limits.
`define AMT_MAX_PKT 7'h40
`define AMT_MAX_BA 4'h9
`define AMT_BA_BYTES 3'h4
// Field widths.
`define AMT_FCOUNT_W 35
`endif

/* File: rtl/amt_pkg.sv */
// Types for the access module message timing block.
package amt_pkg;
    typedef enum logic [4:0] {
        AMT_IDLE = 5'h01,
        AMT_RECV = 5'h02,
        AMT_CALC = 5'h04,
        AMT_SEND = 5'h08,
        AMT_DONE = 5'h10
    } amt_state_t;
endpackage

/* File: rtl/amt_store.sv */
// Assignment store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module amt_store #(
    parameter int DEPTH = 9,
    parameter int AW = 4,
    parameter int DW = 32
) (
    // Clock.
    input wire logic i_mclk,
    // Write port.
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port.
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_r [DEPTH];
    logic [DW-1:0] rdata_r;

    // Memory holds no reset; only written slots are ever read as valid.
    always_ff @(posedge i_mclk) begin
        if (i_we && (32'(i_waddr) < DEPTH)) begin
            mem_r[i_waddr] <= i_wdata;
        end
        rdata_r <= (32'(i_raddr) < DEPTH) ? mem_r[i_raddr] : '0;
    end
    assign o_rdata = rdata_r;
endmodule
`default_nettype wire

/* File: rtl/amt_core.sv */
// Message interpreter and epoch timing of the security module.
// Function
// - Every indication except frame count gets a response or a failure with error code.
// - Frame count indication is absorbed silently, no reply.
// - Health check indication is answered by a health check response.
// - Latest 35-bit frame number is held and used for field creation.
// - Creation answers the access control field, or a creation failure.
// - Whole creation cycle fits one 87.8 us epoch started by host.
// - Module takes outbound packet and acknowledges it.
// - Field loaded within 47 us of ACK, before 65,74 us into epoch; a later load only sets o_late.
// - Background work ends before the IN token appears; the IN token deadline is not checked.
// - Inbound data period ends 2 to 3,5 us before epoch end.
// - Policy-compliant request gets integrity code, else failure code.
// - Up to 9 assignments per indication are stored for later use.
// - Assignment response if all stored with no stray byte, reject if any rejected or a byte is left over.
// - Module is a full-speed device; host sends no start-of-frame.
// - No transfer exceeds 64 bytes; the code refuses only field creation packets longer than 64 bytes.
`timescale 1ns/1ps
`default_nettype none
`include "amt_defines.svh"
module amt_core #(
    parameter int ACF_BUDGET = `AMT_ACF_BUDGET_CYC,
    parameter int LOAD_LATEST = `AMT_LOAD_LATEST_CYC,
    parameter int EPOCH_CYC = `AMT_EPOCH_CYC,
    parameter int MAX_BA = 9
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Epoch start strobe from the same clock domain.
    input wire logic i_epoch_start,
    // Outbound packet bytes from the USB function core.
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    // Policy limit for bandwidth requests, from the key store.
    input wire logic [7:0] i_policy_max,
    // Inbound reply bytes toward the USB transmit buffer.
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    // Rx acknowledge, frame count and status.
    output logic o_rx_ack,
    output logic [`AMT_FCOUNT_W-1:0] o_fcount,
    output logic o_tx_ready,
    output logic o_late,
    output logic [3:0] o_ba_count,
    output logic [31:0] o_ba_rdata
);
    ////////////////////////////////////////////////////////////////////
    // State.
    amt_pkg::amt_state_t st_r, st_nxt;
    logic [7:0] id_r, id_nxt;
    logic [6:0] len_r, len_nxt;
    logic [`AMT_FCOUNT_W-1:0] fc_r, fc_nxt;
    logic fc_ok_r, fc_ok_nxt;
    logic [31:0] acc_r, acc_nxt;
    logic [7:0] rsp_id_r, rsp_id_nxt;
    logic [7:0] err_r, err_nxt;
    logic [31:0] code_r, code_nxt;
    logic [2:0] txi_r, txi_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic [7:0] tx_data_r, tx_data_nxt;
    logic tx_last_r, tx_last_nxt;
    logic ack_r, ack_nxt;
    logic ready_r, ready_nxt;
    logic late_r, late_nxt;
    logic [15:0] ep_r, ep_nxt;
    logic [15:0] calc_r, calc_nxt;
    logic [3:0] ba_n_r, ba_n_nxt;
    logic [3:0] ba_cnt_r, ba_cnt_nxt;
    logic [31:0] ba_w_r, ba_w_nxt;
    logic [1:0] bi_r, bi_nxt;
    logic ba_bad_r, ba_bad_nxt;
    logic st_we;
    logic [31:0] st_rdata;

    // Mixes a byte into a running check word.
    function automatic logic [31:0] mix(input logic [31:0] a,
                                        input logic [7:0] b);
        mix = {a[30:0], a[31]} ^ {24'h0, b} ^ {a[7:0], 24'h0};
    endfunction

    // Byte of the reply word at a given index.
    function automatic logic [7:0] pick(input logic [31:0] w,
                                        input logic [2:0] i);
        case (i)
            3'h2: pick = w[31:24];
            3'h3: pick = w[23:16];
            3'h4: pick = w[15:8];
            default: pick = w[7:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Stored assignments; the newest one is read back for packet approval.
    // With none stored the index wraps out of range and reads as zero.
    amt_store #(.DEPTH(MAX_BA), .AW(4), .DW(32)) u_store (
        .i_mclk(i_mclk),
        .i_we(st_we),
        .i_waddr(ba_n_r),
        .i_wdata(ba_w_nxt),
        .i_raddr(ba_cnt_r - 4'h1),
        .o_rdata(st_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic of the interpreter.
    always_comb begin
        st_nxt = st_r;
        id_nxt = id_r;
        len_nxt = len_r;
        fc_nxt = fc_r;
        fc_ok_nxt = fc_ok_r;
        acc_nxt = acc_r;
        rsp_id_nxt = rsp_id_r;
        err_nxt = err_r;
        code_nxt = code_r;
        txi_nxt = txi_r;
        tx_valid_nxt = 1'b0;
        tx_data_nxt = tx_data_r;
        tx_last_nxt = 1'b0;
        ack_nxt = 1'b0;
        ready_nxt = ready_r;
        late_nxt = late_r;
        calc_nxt = calc_r;
        ba_n_nxt = ba_n_r;
        ba_cnt_nxt = ba_cnt_r;
        ba_w_nxt = ba_w_r;
        bi_nxt = bi_r;
        ba_bad_nxt = ba_bad_r;
        st_we = 1'b0;
        // The epoch counter restarts on every host epoch strobe.
        ep_nxt = i_epoch_start ? 16'h0 : ep_r + 16'h1;
        if (i_epoch_start) begin
            ready_nxt = 1'b0;
        end
        case (st_r)
            amt_pkg::AMT_IDLE: begin
                if (i_rx_valid) begin
                    id_nxt = i_rx_data;
                    len_nxt = 7'h1;
                    acc_nxt = 32'h0;
                    fc_nxt = fc_r;
                    bi_nxt = 2'h0;
                    ba_n_nxt = 4'h0;
                    ba_bad_nxt = 1'b0;
                    st_nxt = i_rx_last ? amt_pkg::AMT_CALC
                                       : amt_pkg::AMT_RECV;
                    ack_nxt = i_rx_last;
                    calc_nxt = 16'h0;
                end
            end
            amt_pkg::AMT_RECV: begin
                if (i_rx_valid) begin
                    len_nxt = len_r + 7'h1;
                    acc_nxt = mix(acc_r, i_rx_data);
                    if (id_r == `AMT_ID_FCOUNT_IND && len_r < 7'h6) begin
                        // Frame number arrives most significant byte first.
                        fc_nxt = {fc_r[`AMT_FCOUNT_W-9:0], i_rx_data};
                    end
                    if (id_r == `AMT_ID_BA_IND) begin
                        ba_w_nxt = {ba_w_r[23:0], i_rx_data};
                        bi_nxt = bi_r + 2'h1;
                        if (bi_r == 2'h3) begin
                            if (ba_n_r < 4'(MAX_BA)) begin
                                st_we = 1'b1;
                                ba_n_nxt = ba_n_r + 4'h1;
                            end else begin
                                ba_bad_nxt = 1'b1;
                            end
                        end
                    end
                    if (i_rx_last) begin
                        st_nxt = amt_pkg::AMT_CALC;
                        ack_nxt = 1'b1;
                        calc_nxt = 16'h0;
                    end
                end
            end
            amt_pkg::AMT_CALC: begin
                calc_nxt = calc_r + 16'h1;
                if (calc_r == 16'(`AMT_CALC_CYC)) begin
                    txi_nxt = 3'h0;
                    st_nxt = amt_pkg::AMT_SEND;
                    err_nxt = `AMT_ERR_NONE;
                    code_nxt = acc_r;
                    case (id_r)
                        `AMT_ID_HEALTH_IND: begin
                            rsp_id_nxt = `AMT_ID_HEALTH_RSP;
                        end
                        `AMT_ID_FCOUNT_IND: begin
                            fc_ok_nxt = 1'b1;
                            st_nxt = amt_pkg::AMT_IDLE;
                        end
                        `AMT_ID_ACF_IND: begin
                            if (!fc_ok_r || len_r > `AMT_MAX_PKT) begin
                                rsp_id_nxt = `AMT_ID_ACF_FAIL;
                                err_nxt = `AMT_ERR_NO_FCOUNT;
                            end else begin
                                rsp_id_nxt = `AMT_ID_ACF_RSP;
                                code_nxt = acc_r ^ fc_r[31:0] ^
                                           {29'h0, fc_r[34:32]};
                            end
                        end
                        `AMT_ID_BR_IND: begin
                            if (acc_r[7:0] <= i_policy_max) begin
                                rsp_id_nxt = `AMT_ID_BR_RSP;
                                code_nxt = mix(acc_r, i_policy_max);
                            end else begin
                                rsp_id_nxt = `AMT_ID_BR_FAIL;
                                err_nxt = `AMT_ERR_POLICY;
                            end
                        end
                        `AMT_ID_BA_IND: begin
                            ba_cnt_nxt = ba_n_r;
                            if (ba_bad_r || bi_r != 2'h0) begin
                                rsp_id_nxt = `AMT_ID_BA_REJ;
                                err_nxt = `AMT_ERR_TOO_MANY;
                            end else begin
                                rsp_id_nxt = `AMT_ID_BA_RSP;
                            end
                        end
                        default: begin
                            rsp_id_nxt = `AMT_ID_GEN_FAIL;
                            err_nxt = `AMT_ERR_UNKNOWN;
                        end
                    endcase
                end
            end
            amt_pkg::AMT_SEND: begin
                // Reply: type, error, then four code bytes.
                tx_valid_nxt = 1'b1;
                txi_nxt = txi_r + 3'h1;
                case (txi_r)
                    3'h0: tx_data_nxt = rsp_id_r;
                    3'h1: tx_data_nxt = err_r;
                    default: tx_data_nxt = pick(code_r, txi_r);
                endcase
                if (txi_r == 3'h5) begin
                    tx_last_nxt = 1'b1;
                    st_nxt = amt_pkg::AMT_DONE;
                end
            end
            amt_pkg::AMT_DONE: begin
                ready_nxt = 1'b1;
                // A load past the budget is flagged for the firmware.
                if (32'(calc_r) > ACF_BUDGET ||
                    32'(ep_r) > LOAD_LATEST) begin
                    late_nxt = 1'b1;
                end
                st_nxt = amt_pkg::AMT_IDLE;
            end
            default: st_nxt = amt_pkg::AMT_IDLE;
        endcase
        if (!i_epoch_start && 32'(ep_r) >= EPOCH_CYC) begin
            ep_nxt = ep_r; // Saturate until the next epoch strobe.
        end
    end

    // Registers of the interpreter.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= amt_pkg::AMT_IDLE;
            id_r <= 8'h00;
            len_r <= 7'h00;
            fc_r <= '0;
            fc_ok_r <= 1'b0;
            acc_r <= 32'h0;
            rsp_id_r <= 8'h00;
            err_r <= 8'h00;
            code_r <= 32'h0;
            txi_r <= 3'h0;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_last_r <= 1'b0;
            ack_r <= 1'b0;
            ready_r <= 1'b0;
            late_r <= 1'b0;
            ep_r <= 16'h0;
            calc_r <= 16'h0;
            ba_n_r <= 4'h0;
            ba_cnt_r <= 4'h0;
            ba_w_r <= 32'h0;
            bi_r <= 2'h0;
            ba_bad_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            id_r <= id_nxt;
            len_r <= len_nxt;
            fc_r <= fc_nxt;
            fc_ok_r <= fc_ok_nxt;
            acc_r <= acc_nxt;
            rsp_id_r <= rsp_id_nxt;
            err_r <= err_nxt;
            code_r <= code_nxt;
            txi_r <= txi_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_data_r <= tx_data_nxt;
            tx_last_r <= tx_last_nxt;
            ack_r <= ack_nxt;
            ready_r <= ready_nxt;
            late_r <= late_nxt;
            ep_r <= ep_nxt;
            calc_r <= calc_nxt;
            ba_n_r <= ba_n_nxt;
            ba_cnt_r <= ba_cnt_nxt;
            ba_w_r <= ba_w_nxt;
            bi_r <= bi_nxt;
            ba_bad_r <= ba_bad_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign o_tx_valid = tx_valid_r;
    assign o_tx_data = tx_data_r;
    assign o_tx_last = tx_last_r;
    assign o_rx_ack = ack_r;
    assign o_fcount = fc_r;
    assign o_tx_ready = ready_r;
    assign o_late = late_r;
    assign o_ba_count = ba_cnt_r;
    assign o_ba_rdata = st_rdata;
endmodule
`default_nettype wire

/* File: testbench/amt_core_assertions.sv */
// Concurrent checks on the message interpreter's ports.
`timescale 1ns/1ps
`default_nettype none
`include "amt_defines.svh"
module amt_core_checker (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Observed inputs.
    input wire logic i_epoch_start,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    // Observed outputs.
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_last,
    input wire logic o_rx_ack,
    input wire logic [`AMT_FCOUNT_W-1:0] o_fcount,
    input wire logic o_tx_ready,
    input wire logic o_late
);
    logic first_r;
    logic first_nxt;
    logic [7:0] id_r;
    logic [7:0] id_nxt;
    ////////////////////////////////////////////////////////////////////////
    // Remember the type byte of the packet in flight to judge its reply.
    always_comb begin
        first_nxt = first_r;
        id_nxt = id_r;
        if (i_rx_valid) begin
            first_nxt = i_rx_last;
            id_nxt = first_r ? i_rx_data : id_r;
        end
    end
    // Registers of the helper logic.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            first_r <= 1'b1;
            id_r <= 8'h00;
        end else begin
            first_r <= first_nxt;
            id_r <= id_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // All checks share one clock and the asynchronous reset.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    burst_len_a: assert property ($rose(o_tx_valid) |->
        (o_tx_valid && !o_tx_last)[*5] ##1 (o_tx_valid && o_tx_last)
        ##1 !o_tx_valid) else $error("reply burst is not six bytes");
    ack_reply_a: assert property (o_rx_ack && id_r != `AMT_ID_FCOUNT_IND
        |-> ##[18:20] $rose(o_tx_valid)) else $error("reply late");
    ack_cause_a: assert property (o_rx_ack
        |-> $past(i_rx_valid && i_rx_last)) else $error("stray ack");
    ready_after_a: assert property (o_tx_last |=> o_tx_ready)
        else $error("ready missing after last byte");
    ready_clear_a: assert property (i_epoch_start && !o_tx_last
        |=> !o_tx_ready) else $error("ready not cleared by epoch");
    no_fc_reply_a: assert property (o_tx_valid
        |-> id_r != `AMT_ID_FCOUNT_IND) else $error("frame count answered");
    health_rsp_a: assert property ($rose(o_tx_valid)
        && id_r == `AMT_ID_HEALTH_IND |-> o_tx_data == `AMT_ID_HEALTH_RSP)
        else $error("wrong health reply");
    dispatch_a: assert property ($rose(o_tx_valid) |->
        o_tx_data[5:0] == id_r[5:0] || o_tx_data == `AMT_ID_GEN_FAIL)
        else $error("reply type does not match request");
    fcount_hold_a: assert property (!$past(i_rx_valid)
        |-> $stable(o_fcount)) else $error("frame count moved idle");
    in_time_a: assert property ($rose(o_tx_ready) |-> !o_late)
        else $error("late flag on timely load");
endmodule
bind amt_core amt_core_checker chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_epoch_start(i_epoch_start), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .o_rx_ack(o_rx_ack),
    .o_fcount(o_fcount), .o_tx_ready(o_tx_ready), .o_late(o_late));
`default_nettype wire

/* File: testbench/amt_host.sv */
// Behavioural terminal host that opens an epoch and sends one packet.
`timescale 1ns/1ps
`default_nettype none
module amt_host (
    // Clock.
    input wire logic i_mclk,
    // Host side of the packet interface.
    output logic o_epoch_start,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_last
);
    ////////////////////////////////////////////////////////////////////////
    // Idle at time zero.
    initial begin
        o_epoch_start = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_last = 1'b0;
    end
    // Packets stay within the transfer limit of 64 bytes.
    task automatic send(input logic [7:0] pkt[$]);
        @(posedge i_mclk);
        #1 o_epoch_start = 1'b1;
        @(posedge i_mclk);
        #1 o_epoch_start = 1'b0;
        // The first byte follows the epoch pulse at once.
        for (int i = 0; i < pkt.size(); i++) begin
            if (i > 0) begin
                @(posedge i_mclk);
                #1;
            end
            o_rx_valid = 1'b1;
            o_rx_data = pkt[i];
            o_rx_last = (i == pkt.size() - 1);
        end
        @(posedge i_mclk);
        #1 o_rx_valid = 1'b0;
        o_rx_last = 1'b0;
        // A released data line must not keep its last value.
        o_rx_data = ~o_rx_data;
    endtask
endmodule
`default_nettype wire

/* File: testbench/access_module_message_timing_tb.sv */
// Self-checking testbench for the message interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "amt_defines.svh"
module access_module_message_timing_tb;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_policy_max = 8'hff;
    logic epoch, rx_valid, rx_last;
    logic [7:0] rx_data;
    logic o_tx_valid, o_tx_last, o_rx_ack, o_tx_ready, o_late;
    logic [7:0] o_tx_data;
    logic [`AMT_FCOUNT_W-1:0] o_fcount;
    logic [3:0] o_ba_count;
    logic [31:0] o_ba_rdata;
    logic [7:0] rep [6];
    logic [7:0] pkt [$];
    int failures = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    always #5 i_mclk = ~i_mclk;
    // Host model and design.
    amt_host host (.i_mclk(i_mclk), .o_epoch_start(epoch),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last));
    amt_core uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_epoch_start(epoch),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
        .i_policy_max(i_policy_max), .o_tx_valid(o_tx_valid),
        .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .o_rx_ack(o_rx_ack),
        .o_fcount(o_fcount), .o_tx_ready(o_tx_ready), .o_late(o_late),
        .o_ba_count(o_ba_count), .o_ba_rdata(o_ba_rdata));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count.
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run.
    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Send the packet and gather the six reply bytes; the bounded wait
    // is far inside the processing budget.
    task automatic xfer();
        int w;
        host.send(pkt);
        w = 0;
        while (o_tx_valid !== 1'b1 && w < 60) begin
            @(posedge i_mclk);
            #1 w++;
        end
        for (int i = 0; i < 6; i++) begin
            rep[i] = o_tx_data;
            chk(o_tx_valid, 1'b1);
            chk(o_tx_last, i == 5);
            @(posedge i_mclk);
            #1;
        end
        chk(o_tx_ready, 1'b1);
        chk(o_late, 1'b0);
    endtask
    // Send, then check type and error code.
    task automatic expect_rep(input logic [7:0] id, input logic [7:0] err);
        xfer();
        chk(rep[0], id);
        chk(rep[1], err);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Field creation before any frame count cannot be computed.
    task automatic t_acf_early();
        pkt = {`AMT_ID_ACF_IND, 8'h12, 8'h34, 8'h56, 8'h78};
        expect_rep(`AMT_ID_ACF_FAIL, `AMT_ERR_NO_FCOUNT);
    endtask
    // Health check and an unknown type.
    task automatic t_health();
        pkt = {`AMT_ID_HEALTH_IND};
        expect_rep(`AMT_ID_HEALTH_RSP, `AMT_ERR_NONE);
        pkt = {8'h7e, 8'h11};
        expect_rep(`AMT_ID_GEN_FAIL, `AMT_ERR_UNKNOWN);
    endtask
    // Two frame counts in a row: silent, latest kept, then used.
    task automatic t_fcount();
        logic [39:0] v;
        logic silent;
        for (int k = 0; k < 2; k++) begin
            v = k ? 40'h0123456789 : 40'hff00000001;
            pkt = {`AMT_ID_FCOUNT_IND, v[39:32], v[31:24], v[23:16],
                v[15:8], v[7:0]};
            host.send(pkt);
            silent = 1'b0;
            repeat (40) begin
                @(posedge i_mclk);
                #1 silent = silent | o_tx_valid;
            end
            chk(silent, 1'b0);
            chk(o_fcount, v[34:0]);
        end
        pkt = {`AMT_ID_ACF_IND, 8'h12, 8'h34, 8'h56, 8'h78};
        expect_rep(`AMT_ID_ACF_RSP, `AMT_ERR_NONE);
    endtask
    // Request of 48 air bytes under an open and a closed policy.
    task automatic t_br();
        pkt = {`AMT_ID_BR_IND};
        for (int i = 16; i < 64; i++) begin
            pkt.push_back(8'(i));
        end
        expect_rep(`AMT_ID_BR_RSP, `AMT_ERR_NONE);
        i_policy_max = 8'h00;
        xfer();
        chk((rep[0] === `AMT_ID_BR_RSP && rep[1] === `AMT_ERR_NONE) ||
            (rep[0] === `AMT_ID_BR_FAIL && rep[1] === `AMT_ERR_POLICY),
            1'b1);
        i_policy_max = 8'hff;
    endtask
    // Nine assignments, ten, and nine with a stray byte.
    task automatic t_ba();
        int nb;
        for (int k = 0; k < 3; k++) begin
            nb = (k == 0) ? 36 : (k == 1) ? 40 : 37;
            pkt = {`AMT_ID_BA_IND};
            for (int i = 0; i < nb; i++) begin
                pkt.push_back(8'(i + 1));
            end
            xfer();
            chk(rep[0], k ? `AMT_ID_BA_REJ : `AMT_ID_BA_RSP);
            if (k == 0) begin
                chk(o_ba_count, 4'h9);
                chk(o_ba_rdata, 32'h21222324);
            end
            if (k == 1) begin
                chk(rep[1], `AMT_ERR_TOO_MANY);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence after six cycles of reset.
    initial begin
        repeat (6) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        t_acf_early();
        t_health();
        t_fcount();
        t_br();
        t_ba();
        summarize();
    end
    // Watchdog, well beyond the few hundred cycles the tests need.
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
